// file: hdl/pcr_pkg.sv
package pcr_pkg;
	// Register byte offsets
	localparam logic [11:0] PCR_CTRL_OFS   = 12'h000;
	localparam logic [11:0] PCR_STATUS_OFS = 12'h004;
	localparam logic [11:0] PCR_PCG_OFS    = 12'h008;
	// Control register field positions
	localparam int PCR_MUL_LSB   = 0;
	localparam int PCR_MUL_W     = 6;
	localparam int PCR_PDIV_LSB  = 8;
	localparam int PCR_HALVE_BIT = 10;
	localparam int PCR_SDR_LSB   = 12;
	localparam int PCR_SDR_W     = 3;
	// Generator register field positions
	localparam int PCR_FSD_LSB   = 0;
	localparam int PCR_FSP_LSB   = 8;
	localparam int PCR_GEN_EN    = 16;
	// Reset values
	localparam logic [1:0] PCR_PDIV_RST  = 2'h0;
	localparam logic [2:0] PCR_SDR_RST   = 3'h2;
	localparam logic [7:0] PCR_FSD_RST   = 8'h04;
	localparam logic [7:0] PCR_FSP_RST   = 8'h00;
	// Multiplier chosen by each strap setting
	localparam logic [5:0] PCR_STRAP_MUL0 = 6'h08;
	localparam logic [5:0] PCR_STRAP_MUL1 = 6'h10;
	localparam logic [5:0] PCR_STRAP_MUL2 = 6'h20;
	localparam logic [5:0] PCR_STRAP_MUL3 = 6'h08;
	// Timing counts
	localparam logic [12:0] PCR_REF_HOLD     = 13'h1000;
	localparam logic [1:0]  PCR_CORE_HOLD    = 2'h2;
	localparam logic [6:0]  PCR_WD_PULSE     = 7'h40;
	localparam logic [4:0]  PCR_GEN_LEAD     = 5'h05;
	localparam logic [1:0]  PCR_FS_WIDTH     = 2'h2;
endpackage

// file: hdl/pcr_clock_reset.sv
// Contract
// [RULE1] Core, memory and serial clocks come from the loop, a multiple of reference; here core and SDRAM clocks divide mclk, no serial clock
// [RULE2] Oscillator multiple equals two times the loop multiplier
// [RULE3] Core clock is oscillator over post divider 2/4/8/16; 2 during reset
// [RULE4] During reset the multiplier comes from the clock ratio straps
// [RULE5] Loop input is reference, or reference halved when halving enabled
// [RULE6] Software keeps reference times multiplier inside oscillator limits
// [RULE7] Peripheral clock period is exactly twice the core clock period
// [RULE8] SDRAM clock period is core period times the SDRAM ratio
// [RULE9] Ratios set by straps during reset, later by software register
// [RULE10] Core held in reset 4096 reference cycles plus 2 core cycles
// [RULE11] A missed sampling window may add one reference cycle, 4097 max
// [RULE12] External source holds reset low at least four reference cycles
// [RULE13] Watchdog reset falls on watchdog clock rise, low 64 periods minimum
// [RULE14] Generator trigger is sampled on falling edge of its input clock
// [RULE15] Generator output clock starts 2.5 input periods after trigger
// [RULE16] Frame sync follows trigger by 2.5 plus divisor minus phase periods
// [RULE17] Reset delay counts synced reference cycles, restarts on new reset
// [RULE18] Software ratio changes never cause runt clock pulses
`timescale 1ns/1ps
module pcr_clock_reset
	import pcr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reference_clock_input,
	input  wire logic        reset_in_n,
	input  wire logic [1:0]  clock_ratio_strap,
	input  wire logic        watchdog_clock,
	input  wire logic        watchdog_expire,
	input  wire logic        gen_input_clock,
	input  wire logic        gen_trigger,
	output logic             core_clock,
	output logic             peripheral_clock,
	output logic             sdram_clock,
	output logic             core_reset,
	output logic             reset_output_n,
	output logic             gen_clock_out,
	output logic             gen_frame_sync
);
	// Pin synchronisers: stage one feeds stage two only
	// Straps are static while sampled, so each bit may cross on its own
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	always_ff @(posedge mclk) begin
		sync1_q <= {gen_trigger, gen_input_clock, watchdog_clock, clock_ratio_strap,
			reset_in_n, reference_clock_input};
		sync2_q <= sync1_q;
	end
	wire       ref_s   = sync2_q[0];
	wire       rstn_s  = sync2_q[1];
	wire [1:0] strap_s = sync2_q[3:2];
	wire       wdc_s   = sync2_q[4];
	wire       gclk_s  = sync2_q[5];
	wire       gtrg_s  = sync2_q[6];

	// Edge history of synced clocks
	logic ref_d_q;
	logic wdc_d_q;
	logic gclk_d_q;
	always_ff @(posedge mclk) begin
		ref_d_q  <= ref_s;
		wdc_d_q  <= wdc_s;
		gclk_d_q <= gclk_s;
	end
	wire ref_rise  = ref_s & ~ref_d_q;
	wire wdc_rise  = wdc_s & ~wdc_d_q;
	wire gclk_fall = ~gclk_s & gclk_d_q;
	wire gclk_edge = gclk_s ^ gclk_d_q;

	// Control and generator register state
	logic [5:0] mul_q;
	logic [1:0] pdiv_q;
	logic       halve_q;
	logic [2:0] sdr_q;
	logic [7:0] fsd_q;
	logic [7:0] fsp_q;
	logic       gen_en_q;

	// Strap decode; straps only steer the loop while core reset holds
	wire [5:0] strap_mul = (strap_s == 2'h0) ? PCR_STRAP_MUL0 :
		(strap_s == 2'h1) ? PCR_STRAP_MUL1 :
		(strap_s == 2'h2) ? PCR_STRAP_MUL2 : PCR_STRAP_MUL3;
	// Effective loop settings; register values apply once core reset ends
	wire [5:0] eff_mul  = core_reset ? strap_mul : mul_q;   // [RULE4]
	wire [1:0] eff_pdiv = core_reset ? PCR_PDIV_RST : pdiv_q; // [RULE3]
	// Oscillator multiple of the loop input, and of the reference itself
	wire [6:0] vco_mult = {eff_mul, 1'b0};                    // [RULE2]
	wire [7:0] vco_ref  = halve_q ? {2'b00, eff_mul} : {1'b0, vco_mult}; // [RULE5]

	// Core reset sequencing: synced release, 4096 reference edges, 2 core edges
	// A release that just misses the synchroniser costs one more reference edge
	// Any new pin low or bus reset restarts both counts from zero
	logic [12:0] ref_cnt_q;
	logic [1:0]  core_cnt_q;
	logic        core_rise;
	wire         ref_done  = (ref_cnt_q == PCR_REF_HOLD);
	wire         core_done = (core_cnt_q == PCR_CORE_HOLD);
	always_ff @(posedge mclk) begin
		if (rst || !rstn_s) begin
			ref_cnt_q  <= 13'h0000;                            // [RULE17]
			core_cnt_q <= 2'h0;
			core_reset <= 1'b1;
		end else begin
			if (ref_rise && !ref_done)
				ref_cnt_q <= ref_cnt_q + 13'h0001;             // [RULE10] [RULE11]
			if (ref_done && core_rise && !core_done)
				core_cnt_q <= core_cnt_q + 2'h1;
			if (core_done)
				core_reset <= 1'b0;                            // [RULE10]
		end
	end

	// Core clock divider; new divider taken only at a period boundary
	// Half period in mclk cycles, reloaded only as a high phase ends,
	// so a ratio change never shortens a pulse
	logic [3:0] half_q;
	logic [3:0] hcnt_q;
	wire  [3:0] half_new = 4'h1 << eff_pdiv;
	wire        half_end = (hcnt_q == half_q - 4'h1);
	assign core_rise = half_end & ~core_clock;
	always_ff @(posedge mclk) begin
		if (rst) begin
			core_clock <= 1'b0;
			hcnt_q     <= 4'h0;
			half_q     <= 4'h1;
		end else if (half_end) begin
			core_clock <= ~core_clock;                         // [RULE1]
			hcnt_q     <= 4'h0;
			if (core_clock)
				half_q <= half_new;                            // [RULE18]
		end else begin
			hcnt_q <= hcnt_q + 4'h1;
		end
	end

	// Peripheral clock at half the core rate, SDRAM clock at core over ratio
	// Ratio zero acts as one; a new ratio waits for the end of a high phase
	logic [2:0] sdr_cur_q;
	logic [2:0] sdr_cnt_q;
	wire  [2:0] sdr_lim  = (sdr_cur_q == 3'h0) ? 3'h1 : sdr_cur_q;
	wire        sdr_edge = half_end && (sdr_cnt_q == sdr_lim - 3'h1);
	always_ff @(posedge mclk) begin
		if (rst) begin
			peripheral_clock <= 1'b0;
			sdram_clock      <= 1'b0;
			sdr_cnt_q        <= 3'h0;
			sdr_cur_q        <= PCR_SDR_RST;
		end else begin
			if (core_rise)
				peripheral_clock <= ~peripheral_clock;         // [RULE7]
			if (sdr_edge) begin
				sdram_clock <= ~sdram_clock;                   // [RULE8]
				sdr_cnt_q   <= 3'h0;
				if (sdram_clock)
					sdr_cur_q <= sdr_q;                        // [RULE18]
			end else if (half_end) begin
				sdr_cnt_q <= sdr_cnt_q + 3'h1;
			end
		end
	end

	// Watchdog reset pulse: arm on expiry, fall on watchdog clock rise
	// An expiry during a pulse re-arms for one more pulse afterwards
	logic       wd_arm_q;
	logic [6:0] wd_cnt_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			wd_arm_q       <= 1'b0;
			wd_cnt_q       <= 7'h00;
			reset_output_n <= 1'b1;
		end else begin
			if (watchdog_expire)
				wd_arm_q <= 1'b1;
			if (wdc_rise && wd_arm_q && reset_output_n) begin
				reset_output_n <= 1'b0;                        // [RULE13]
				wd_arm_q       <= watchdog_expire;
				wd_cnt_q       <= 7'h00;
			end else if (wdc_rise && !reset_output_n) begin
				if (wd_cnt_q == PCR_WD_PULSE - 7'h01)
					reset_output_n <= 1'b1;                    // [RULE13]
				wd_cnt_q <= wd_cnt_q + 7'h01;
			end
		end
	end

	// Precision generator: edges counted in input half periods
	// Clock and frame sync both wait for the fifth input edge after the trigger
	// A phase at or above the divisor puts the first frame sync on that edge
	logic        gen_run_q;
	logic [4:0]  lead_q;
	logic        clk_on_q;
	logic [8:0]  fs_cnt_q;
	logic [1:0]  fs_w_q;
	wire  [7:0]  fs_gap   = (fsd_q > fsp_q) ? (fsd_q - fsp_q) : 8'h00;
	wire  [8:0]  fs_first = {fs_gap, 1'b0};
	wire  [8:0]  fs_again = (fsd_q == 8'h00) ? 9'h002 : {fsd_q, 1'b0};
	always_ff @(posedge mclk) begin
		if (rst || !gen_en_q) begin
			gen_run_q      <= 1'b0;
			lead_q         <= 5'h00;
			clk_on_q       <= 1'b0;
			fs_cnt_q       <= 9'h000;
			fs_w_q         <= 2'h0;
			gen_clock_out  <= 1'b0;
			gen_frame_sync <= 1'b0;
		end else if (!gen_run_q) begin
			if (gclk_fall && gtrg_s) begin
				gen_run_q <= 1'b1;                             // [RULE14]
				lead_q    <= 5'h00;
				fs_cnt_q  <= fs_first;
			end
		end else if (gclk_edge) begin
			if (lead_q != PCR_GEN_LEAD)
				lead_q <= lead_q + 5'h01;
			if (lead_q == PCR_GEN_LEAD - 5'h01) begin
				clk_on_q      <= 1'b1;
				gen_clock_out <= 1'b1;                         // [RULE15]
			end else if (clk_on_q && gclk_fall) begin
				gen_clock_out <= ~gen_clock_out;
			end
			if (lead_q == PCR_GEN_LEAD - 5'h01 || lead_q == PCR_GEN_LEAD) begin
				if (fs_w_q != 2'h0) begin
					fs_w_q <= fs_w_q - 2'h1;
					if (fs_w_q == 2'h1)
						gen_frame_sync <= 1'b0;
				end
				if (fs_cnt_q == 9'h000 && lead_q == PCR_GEN_LEAD - 5'h01 ||
					fs_cnt_q == 9'h001 && lead_q == PCR_GEN_LEAD) begin
					gen_frame_sync <= 1'b1;                    // [RULE16]
					fs_w_q         <= PCR_FS_WIDTH;
					fs_cnt_q       <= fs_again;
				end else if (lead_q == PCR_GEN_LEAD) begin
					fs_cnt_q <= fs_cnt_q - 9'h001;
				end
			end
		end
	end

	// APB decode
	wire [11:0] ofs     = paddr[11:0];
	wire        hit_ctl = (ofs == PCR_CTRL_OFS);
	wire        hit_sts = (ofs == PCR_STATUS_OFS);
	wire        hit_gen = (ofs == PCR_PCG_OFS);
	wire        mapped  = (paddr[31:12] == 20'h00000) & (hit_ctl | hit_sts | hit_gen);
	wire        access  = psel & penable & ~pready;
	wire        wr_take = psel & penable & pready & pwrite & mapped;
	wire [31:0] ctl_rd  = {17'h00000, sdr_q, 1'b0, halve_q, pdiv_q, 2'h0, mul_q};
	// Status: divider, straps, run, resets, then the two oscillator multiples
	wire [31:0] sts_rd  = {8'h00, vco_ref, vco_mult, 2'h0, core_reset, reset_output_n,
		gen_run_q, strap_s, eff_pdiv};
	wire [31:0] gen_rd  = {15'h0000, gen_en_q, fsp_q, fsd_q};
	wire [31:0] rd_mux  = hit_ctl ? ctl_rd : hit_sts ? sts_rd : hit_gen ? gen_rd : 32'h0;

	// APB answer: one wait state, error on unmapped address
	// Ready drops right after each answer, so a held request is answered again only every second cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access;
			pslverr <= access & ~mapped;
			prdata  <= (access && !pwrite && mapped) ? rd_mux : 32'h00000000;
		end
	end

	// Register writes; straps load the multiplier as core reset holds
	// Generator writes also wait for core reset to end
	always_ff @(posedge mclk) begin
		if (rst) begin
			mul_q    <= PCR_STRAP_MUL0;
			pdiv_q   <= PCR_PDIV_RST;
			halve_q  <= 1'b0;
			sdr_q    <= PCR_SDR_RST;
			fsd_q    <= PCR_FSD_RST;
			fsp_q    <= PCR_FSP_RST;
			gen_en_q <= 1'b0;
		end else if (core_reset) begin
			mul_q  <= strap_mul;                               // [RULE9]
			pdiv_q <= PCR_PDIV_RST;
		end else if (wr_take && hit_ctl) begin
			mul_q   <= pwdata[PCR_MUL_LSB +: PCR_MUL_W];       // [RULE9]
			pdiv_q  <= pwdata[PCR_PDIV_LSB +: 2];
			halve_q <= pwdata[PCR_HALVE_BIT];
			sdr_q   <= pwdata[PCR_SDR_LSB +: PCR_SDR_W];
		end else if (wr_take && hit_gen) begin
			fsd_q    <= pwdata[PCR_FSD_LSB +: 8];
			fsp_q    <= pwdata[PCR_FSP_LSB +: 8];
			gen_en_q <= pwdata[PCR_GEN_EN];
		end
	end
endmodule

// file: tb/pcr_props.sv
`timescale 1ns/1ps
module pcr_props (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        reset_in_n,
	input wire logic        core_clock,
	input wire logic        core_reset,
	input wire logic        reset_output_n
);
	localparam int HOLD_MIN = 16380;
	localparam int HOLD_MAX = 16430;
	localparam int WD_MIN   = 1260;
	logic [15:0] hi_q;
	logic [15:0] lo_q;
	// Cycles since pin release; cycles of watchdog reset low
	always_ff @(posedge mclk) begin
		hi_q <= (rst || !reset_in_n) ? 16'h0000 : hi_q + {15'h0000, ~&hi_q};
		lo_q <= reset_output_n ? 16'h0000 : lo_q + 16'h0001;
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rdy; pready |=> !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready held");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_idle; !pready |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("stray data");
	property p_div; core_reset [*8] |-> $changed(core_clock); endproperty
	a_div: assert property (p_div) else $error("divider in reset");
	property p_min; $fell(core_reset) |-> hi_q >= HOLD_MIN; endproperty
	a_min: assert property (p_min) else $error("early release");
	property p_max; hi_q > HOLD_MAX |-> !core_reset; endproperty
	a_max: assert property (p_max) else $error("late release");
	property p_pin; !reset_in_n [*5] |=> core_reset; endproperty
	a_pin: assert property (p_pin) else $error("pin ignored");
	property p_wd; $rose(reset_output_n) |-> $past(lo_q) >= WD_MIN; endproperty
	a_wd: assert property (p_wd) else $error("short pulse");
	c_up: cover property ($fell(core_reset));
	c_wd: cover property ($fell(reset_output_n));
	c_err: cover property (pslverr);
endmodule
bind pcr_clock_reset pcr_props pcr_props_inst (.mclk(mclk), .rst(rst), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .reset_in_n(reset_in_n),
	.core_clock(core_clock), .core_reset(core_reset), .reset_output_n(reset_output_n));

// file: tb/pcr_osc_model.sv
`timescale 1ns/1ps
module pcr_osc_model (
	input  wire logic mclk,
	input  wire logic reset_req,
	output logic      ref_ck,
	output logic      rst_n,
	output logic      wd_ck,
	output logic      gen_ck
);
	logic [7:0] hold_q;
	// Free running oscillators: 20, 100 and 80 ns
	initial begin
		ref_ck = 1'b0;
		wd_ck = 1'b0;
		gen_ck = 1'b0;
		fork
			forever #10 ref_ck = ~ref_ck;
			forever #50 wd_ck = ~wd_ck;
			forever #40 gen_ck = ~gen_ck;
		join
	end
	// Pin held low 24 cycles on each request
	always_ff @(posedge mclk) begin
		if (reset_req) begin
			hold_q <= 8'h18;
		end else if (hold_q != 8'h00) begin
			hold_q <= hold_q - 8'h01;
		end
	end
	assign rst_n = (hold_q == 8'h00);
endmodule

// file: tb/pcr_clock_reset_tb.sv
`timescale 1ns/1ps
module pcr_clock_reset_tb;
	import pcr_pkg::*;
	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, rq, wx, tr;
	logic        rf, rn, wc, gc, cc, pc, sc, cr, ro, go, fs;
	logic [1:0]  st;
	logic [31:0] paddr, pwdata, prdata, q, xv;
	logic [6:0]  mon;
	logic [5:0]  smul [4];
	int          err_count, comparisons, cyc, n, m;
	assign mon = {fs, go, ro, cr, sc, pc, cc};
	assign smul = '{PCR_STRAP_MUL0, PCR_STRAP_MUL1, PCR_STRAP_MUL2, PCR_STRAP_MUL3};
	pcr_clock_reset pcr_clock_reset_inst (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reference_clock_input(rf), .reset_in_n(rn),
		.clock_ratio_strap(st), .watchdog_clock(wc), .watchdog_expire(wx),
		.gen_input_clock(gc), .gen_trigger(tr), .core_clock(cc), .peripheral_clock(pc),
		.sdram_clock(sc), .core_reset(cr), .reset_output_n(ro), .gen_clock_out(go),
		.gen_frame_sync(fs));
	pcr_osc_model pcr_osc_model_inst (.mclk(mclk), .reset_req(rq), .ref_ck(rf),
		.rst_n(rn), .wd_ck(wc), .gen_ck(gc));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Hang limit
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; data lands in q
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h00000, a};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] k, input logic [31:0] x,
		input logic xe);
		logic e;
		apb(1'b0, a, 32'h0, e);
		chk(q & k, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
	endtask
	task automatic wt(input int i, input logic v, output int c);
		c = 0;
		while (mon[i] !== v) begin
			@(posedge mclk);
			c++;
		end
	endtask
	// Period between two rises, in mclk cycles
	task automatic per(input int i, input int x);
		wt(i, 1'b0, n);
		wt(i, 1'b1, n);
		wt(i, 1'b0, n);
		wt(i, 1'b1, m);
		chk(n + m, x);
	endtask
	initial begin
		{rst, rq, psel, penable, pwrite, wx, tr} <= 7'h60;
		{paddr, pwdata, st} <= 66'h0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rq <= 1'b0;
		// Each strap through a pin reset; strap 0 uses the opening one, straps 1 to 3 a fresh one
		for (int s = 0; s < 4; s++) begin
			st <= s[1:0];
			@(posedge mclk);
			rq <= (s != 0);
			@(posedge mclk);
			rq <= 1'b0;
			wt(3, 1'b1, n);
			wt(3, 1'b0, n);
			rd(PCR_CTRL_OFS, 32'h3f, {26'h0, smul[s]}, 1'b0);
			// Oscillator multiple is twice the strap multiplier, same per reference
			xv = {8'h00, 1'b0, smul[s], 1'b0, smul[s], 1'b0, 5'h00, s[1:0], 2'h0};
			rd(PCR_STATUS_OFS, 32'hfffe0c, xv, 1'b0);
			if (s == 0) begin
				per(0, 2);
				per(1, 4);
				per(2, 4);
			end
		end
		// Each post divider, halving on, SDRAM ratio 3
		for (int s = 0; s < 4; s++) begin
			wr(PCR_CTRL_OFS, 32'h340c | (s << PCR_PDIV_LSB));
			repeat (20) @(posedge mclk);
			per(0, 2 << s);
			per(1, 4 << s);
			per(2, 6 << s);
			// Halved input: oscillator multiple 24, twelve per reference period
			xv = {8'h00, 8'h0c, 7'h18, 7'h00, s[1:0]};
			rd(PCR_STATUS_OFS, 32'hfffe03, xv, 1'b0);
		end
		rd(12'h00c, 32'hffffffff, 32'h0, 1'b1);
		wx <= 1'b1;
		@(posedge mclk);
		wx <= 1'b0;
		wt(4, 1'b0, n);
		rd(PCR_STATUS_OFS, 32'h20, 32'h0, 1'b0);
		wt(4, 1'b1, n);
		chk({31'h0, n > 1200}, 32'h1);
		wr(PCR_PCG_OFS, 32'h10104);
		tr <= 1'b1;
		repeat (20) @(posedge mclk);
		tr <= 1'b0;
		wt(5, 1'b1, n);
		wt(6, 1'b1, m);
		chk(m, 48);
		per(5, 32);
		per(6, 64);
		rd(PCR_STATUS_OFS, 32'h10, 32'h10, 1'b0);
		stop_test();
	end
endmodule
